// >>> hw/pnp_host_pkg.sv
// Constants for the plug and play isolation host
// How it works
// RQ1: Three shared byte ports: address 0x0279, write data 0x0a79, read data.
// RQ2: Configuration ports are decoded from twelve address bits only.
// RQ3: Read data port sits anywhere in 0x0203..0x03ff and is read only.
// RQ4: Host writes the fixed 32 byte key, 6a first, 39 last.
// RQ5: Device looks for the key only while waiting for key.
// RQ6: A complete key enables configuration and puts the card into isolation.
// RQ7: Isolation is 72 read pairs of the serial isolation register.
// RQ8: A bit is one only when the pair reads 0x55 then 0xaa.
// RQ9: Host checksums the decided bits and compares with the last eight.
// RQ10: Checksum bits are only meaningful during serial isolation.
// RQ11: Wake zero sends unnumbered cards to isolation and restarts their identifier.
// RQ12: Bad checksum or no pattern: issue wake zero, relocate read port, wait.
// RQ13: Losing cards sleep, the winner stays in isolation.
// RQ14: Writing a card number to the isolated card moves it to configuration.
// RQ15: Ready is never driven in isolation, elsewhere only if enabled.
// RQ16: Wait 1 ms before first pair, 250 us between later pairs.
// RQ17: Wait 2 ms after bus reset or reset command before any port access.
// RQ18: Bus reset or wait for key command returns cards to wait for key.
// RQ19: Reset command restores device registers, keeps number, port and state.
// RQ20: Avoid run time register writes; deactivate the device before changing any.
// RQ21: Resource data goes through the serial port and blocks it while busy.
// RQ22: Key detector restarts from the first byte on any mismatch.
package pnp_host_pkg;
  localparam logic [15:0] PNP_ADDR_PORT = 16'h0279;
  localparam logic [15:0] PNP_WDATA_PORT = 16'h0a79;
  localparam logic [7:0] RDP_MIN_IDX = 8'h80;
  localparam logic [1:0] RDP_LOW_BITS = 2'h3;
  localparam logic [3:0] ADDR_UNUSED_HI = 4'h0;
  localparam logic [7:0] KEY_SEED = 8'h6a;
  localparam logic [7:0] KEY_LAST = 8'h39;
  localparam logic [5:0] KEY_LEN = 6'h20;
  localparam logic [6:0] ISO_PAIRS = 7'h48;
  localparam logic [6:0] ID_BITS = 7'h40;
  localparam logic [7:0] PAT_ONE_A = 8'h55;
  localparam logic [7:0] PAT_ONE_B = 8'haa;
  localparam logic [7:0] REG_SET_RDP = 8'h00;
  localparam logic [7:0] REG_SERIAL_ISO = 8'h01;
  localparam logic [7:0] REG_CFG_CTRL = 8'h02;
  localparam logic [7:0] REG_WAKE = 8'h03;
  localparam logic [7:0] REG_CSN = 8'h06;
  localparam logic [7:0] CFG_WAIT_KEY = 8'h02;
  localparam logic [7:0] CSN_FIRST = 8'h01;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RST_WAIT_US = 2000;
  localparam int unsigned ISO_FIRST_US = 1000;
  localparam int unsigned ISO_PAIR_US = 250;
  localparam int unsigned RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ;
  localparam int unsigned ISO_FIRST_CYC = ISO_FIRST_US * CLK_MHZ;
  localparam int unsigned ISO_PAIR_CYC = ISO_PAIR_US * CLK_MHZ;
  localparam int unsigned RSTDRV_NS = 1000;
  localparam int unsigned IO_SETUP_NS = 100;
  localparam int unsigned IO_STROBE_NS = 500;
  localparam int unsigned IO_RECOV_NS = 200;
  localparam int unsigned RSTDRV_CYC = (RSTDRV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IO_SETUP_CYC = (IO_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IO_STROBE_CYC = (IO_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IO_RECOV_CYC = (IO_RECOV_NS * CLK_MHZ + 999) / 1000;
endpackage : pnp_host_pkg

// >>> hw/pnp_bus_if.sv
// Request channel from the sequencer to the bus cycle engine
`timescale 1ns/1ps
interface pnp_bus_if;
  logic req;
  logic wr;
  logic ignore_rdy;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport master (output req, output wr, output ignore_rdy, output addr, output wdata,
                  input ack, input rdata);
  modport engine (input req, input wr, input ignore_rdy, input addr, input wdata,
                  output ack, output rdata);
endinterface : pnp_bus_if

// >>> hw/pnp_lfsr.sv
// Key generator and identifier checksum register
`timescale 1ns/1ps
module pnp_lfsr
  import pnp_host_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_init,
  input wire logic i_step,
  input wire logic i_bit,
  output logic [7:0] o_value
);
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_init) begin
      o_value <= KEY_SEED;
    end else if (i_step) begin
      o_value <= {o_value[1] ^ o_value[0] ^ i_bit, o_value[7:1]};
    end
  end
endmodule : pnp_lfsr

// >>> hw/isa_io_cycle.sv
// Byte wide ISA I/O cycle engine
`timescale 1ns/1ps
module isa_io_cycle
  import pnp_host_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  pnp_bus_if.engine bus,
  input wire logic [7:0] i_data,
  input wire logic i_iochrdy,
  output logic [15:0] o_isa_addr,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [7:0] o_data,
  output logic o_data_oe
);
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001, E_SETUP = 4'b0010, E_STB = 4'b0100, E_REC = 4'b1000
  } eng_t;
  localparam int STB = IO_STROBE_CYC;
  eng_t st;
  logic [7:0] cnt;
  logic wr;
  logic ign;

  if (IO_SETUP_CYC > 255 || IO_STROBE_CYC > 255 || IO_RECOV_CYC > 255 ||
      IO_SETUP_CYC < 1 || IO_RECOV_CYC < 1) begin : g_chk
    $error("isa_io_cycle: phase counts do not fit the counter");
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st <= E_IDLE;
      cnt <= 8'h00;
    end else begin
      case (st)
        E_IDLE: if (bus.req) begin
          st <= E_SETUP;
          cnt <= 8'(IO_SETUP_CYC - 1);
        end
        E_SETUP: if (cnt == 8'h00) begin
          st <= E_STB;
          cnt <= 8'(IO_STROBE_CYC - 1);
        end else cnt <= cnt - 8'h01;
        // RQ15 ready ignored on isolation reads
        E_STB: if (cnt != 8'h00) cnt <= cnt - 8'h01;
        else if (ign || i_iochrdy) begin
          st <= E_REC;
          cnt <= 8'(IO_RECOV_CYC - 1);
        end
        E_REC: if (cnt == 8'h00) st <= E_IDLE;
        else cnt <= cnt - 8'h01;
        default: st <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_isa_addr <= 16'h0000;
      o_data <= 8'h00;
      wr <= 1'b0;
      ign <= 1'b0;
      bus.rdata <= 8'h00;
    end else begin
      if (st == E_IDLE && bus.req) begin
        o_isa_addr <= bus.addr;
        o_data <= bus.wdata;
        wr <= bus.wr;
        ign <= bus.ignore_rdy;
      end
      if (st == E_STB && cnt == 8'h00 && !wr) bus.rdata <= i_data;
    end
  end

  assign bus.ack = (st == E_REC) && (cnt == 8'h00);
  assign o_ior_n = !(st == E_STB && !wr);
  assign o_iow_n = !(st == E_STB && wr);
  assign o_data_oe = wr && (st != E_IDLE);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_STROBE_IGN: assert property ($fell(o_ior_n) && ign |-> ##STB $rose(o_ior_n)) // RQ15
    else $error("isolation read strobe length wrong");
  AST_WR_PORTS: assert property (!o_iow_n |->
      (o_isa_addr == PNP_ADDR_PORT || o_isa_addr == PNP_WDATA_PORT)) // RQ1
    else $error("write outside the two write ports");
  AST_ADDR12: assert property (!(o_ior_n && o_iow_n) |-> o_isa_addr[15:12] == ADDR_UNUSED_HI) // RQ2
    else $error("address above twelve bits");
  AST_ONE_STROBE: assert property (o_data_oe |-> o_ior_n) // RQ1
    else $error("read strobe while driving data");
endmodule : isa_io_cycle

// >>> hw/pnp_isolation_host.sv
// Plug and play enumeration host: key, wake, serial isolation, number assignment
`timescale 1ns/1ps
module pnp_isolation_host
  import pnp_host_pkg::*;
#(
  parameter int unsigned RST_WAIT_CYCLES = RST_WAIT_CYC,
  parameter int unsigned ISO_FIRST_CYCLES = ISO_FIRST_CYC,
  parameter int unsigned ISO_PAIR_CYCLES = ISO_PAIR_CYC,
  parameter logic [3:0] MAX_RETRY = 4'h4,
  parameter logic [7:0] RDP_START_IDX = 8'h80,
  parameter logic [7:0] RELOC_STEP = 8'h04
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic i_iochrdy,
  output logic [15:0] o_isa_addr,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_reset_drv,
  output logic o_busy,
  output logic o_done,
  output logic o_card_valid,
  output logic [63:0] o_card_id,
  output logic [7:0] o_card_csn,
  output logic [9:0] o_rd_port
);
  typedef enum logic [13:0] {
    S_RSTDRV  = 14'b00000000000001,
    S_RSTWAIT = 14'b00000000000010,
    S_IDLE    = 14'b00000000000100,
    S_KEY     = 14'b00000000001000,
    S_CMD_A   = 14'b00000000010000,
    S_CMD_D   = 14'b00000000100000,
    S_ISOWAIT = 14'b00000001000000,
    S_ISOSEL  = 14'b00000010000000,
    S_RD1     = 14'b00000100000000,
    S_RD2     = 14'b00001000000000,
    S_DECIDE  = 14'b00010000000000,
    S_GAP     = 14'b00100000000000,
    S_CHECK   = 14'b01000000000000,
    S_DONE    = 14'b10000000000000
  } state_t;

  function automatic logic on_bus(input state_t s);
    return s inside {S_KEY, S_CMD_A, S_CMD_D, S_ISOSEL, S_RD1, S_RD2};
  endfunction : on_bus

  if (RST_WAIT_CYCLES < 1 || ISO_FIRST_CYCLES < 1 || ISO_PAIR_CYCLES < 1 ||
      MAX_RETRY == 4'h0 || RDP_START_IDX < RDP_MIN_IDX || RELOC_STEP == 8'h00) begin : g_chk
    $error("pnp_isolation_host: parameter out of range");
  end

  pnp_bus_if bus ();

  state_t state;
  state_t cmd_ret;
  logic [31:0] wait_cnt;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_val;
  logic cmd2_valid;
  logic [7:0] cmd2_reg;
  logic [7:0] cmd2_val;
  logic [3:0] retry;
  logic [7:0] rdp_idx;
  logic [7:0] csn;
  logic [5:0] key_cnt;
  logic [6:0] bit_idx;
  logic [7:0] rd1;
  logic [7:0] rd2;
  logic [63:0] id;
  logic [7:0] chk;
  logic any_one;
  logic [7:0] lfsr;
  logic pair_one;
  logic success;
  logic [8:0] next_rdp;

  assign pair_one = (rd1 == PAT_ONE_A) && (rd2 == PAT_ONE_B);
  assign success = any_one && (chk == lfsr);
  assign next_rdp = {1'b0, rdp_idx} + {1'b0, RELOC_STEP};

  pnp_lfsr u_lfsr (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_init(state inside {S_IDLE, S_DONE, S_ISOWAIT}),
    .i_step((state == S_KEY && bus.ack) || (state == S_DECIDE && bit_idx < ID_BITS)),
    .i_bit(state == S_DECIDE && pair_one),
    .o_value(lfsr)
  );

  isa_io_cycle u_cycle (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .bus(bus.engine),
    .i_data(i_data),
    .i_iochrdy(i_iochrdy),
    .o_isa_addr(o_isa_addr),
    .o_ior_n(o_ior_n),
    .o_iow_n(o_iow_n),
    .o_data(o_data),
    .o_data_oe(o_data_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request decode
  always_comb begin
    bus.req = on_bus(state);
    bus.wr = !(state inside {S_RD1, S_RD2});
    // RQ15 isolation reads ignore ready
    bus.ignore_rdy = state inside {S_RD1, S_RD2};
    bus.addr = PNP_ADDR_PORT;
    bus.wdata = cmd_reg;
    case (state)
      // RQ4 key bytes from generator
      S_KEY: bus.wdata = lfsr;
      S_CMD_D: begin
        bus.addr = PNP_WDATA_PORT;
        bus.wdata = cmd_val;
      end
      S_ISOSEL: bus.wdata = REG_SERIAL_ISO;
      // RQ3 relocatable read port
      S_RD1, S_RD2: bus.addr = {6'h00, rdp_idx, RDP_LOW_BITS};
      default: bus.wdata = cmd_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and its timer
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= S_RSTDRV;
      wait_cnt <= 32'(RSTDRV_CYC - 1);
      cmd_reg <= REG_WAKE;
      cmd_val <= 8'h00;
      cmd_ret <= S_DONE;
      cmd2_valid <= 1'b0;
      cmd2_reg <= REG_SET_RDP;
      cmd2_val <= 8'h00;
      retry <= 4'h0;
      rdp_idx <= RDP_START_IDX;
      csn <= CSN_FIRST;
    end else begin
      case (state)
        S_RSTDRV: if (wait_cnt == 32'd0) begin
          state <= S_RSTWAIT;
          wait_cnt <= 32'(RST_WAIT_CYCLES - 1);
        end else wait_cnt <= wait_cnt - 32'd1;
        // RQ17 quiet after bus reset
        S_RSTWAIT: if (wait_cnt == 32'd0) state <= S_IDLE;
        else wait_cnt <= wait_cnt - 32'd1;
        S_IDLE, S_DONE: if (i_start) state <= S_KEY;
        // RQ11 wake then place the read port
        S_KEY: if (bus.ack && key_cnt == KEY_LEN - 6'h01) begin
          state <= S_CMD_A;
          cmd_reg <= REG_WAKE;
          cmd_val <= 8'h00;
          cmd2_valid <= 1'b1;
          cmd2_reg <= REG_SET_RDP;
          cmd2_val <= rdp_idx;
          cmd_ret <= S_ISOWAIT;
        end
        S_CMD_A: if (bus.ack) state <= S_CMD_D;
        S_CMD_D: if (bus.ack) begin
          if (cmd2_valid) begin
            cmd2_valid <= 1'b0;
            cmd_reg <= cmd2_reg;
            cmd_val <= cmd2_val;
            state <= S_CMD_A;
          end else begin
            state <= cmd_ret;
            wait_cnt <= 32'(ISO_FIRST_CYCLES - 1);
          end
        end
        // RQ16 settle before first pair
        S_ISOWAIT: if (wait_cnt == 32'd0) state <= S_ISOSEL;
        else wait_cnt <= wait_cnt - 32'd1;
        S_ISOSEL: if (bus.ack) state <= S_RD1;
        S_RD1: if (bus.ack) state <= S_RD2;
        S_RD2: if (bus.ack) state <= S_DECIDE;
        // RQ7 count the pairs
        S_DECIDE: if (bit_idx == ISO_PAIRS - 7'h01) state <= S_CHECK;
        else begin
          state <= S_GAP;
          wait_cnt <= 32'(ISO_PAIR_CYCLES - 1);
        end
        // RQ16 spacing between pairs
        S_GAP: if (wait_cnt == 32'd0) state <= S_RD1;
        else wait_cnt <= wait_cnt - 32'd1;
        S_CHECK: begin
          state <= S_CMD_A;
          cmd_ret <= S_ISOWAIT;
          cmd2_valid <= 1'b1;
          if (success) begin
            // RQ14 number the isolated card, RQ13 losers already sleep
            cmd_reg <= REG_CSN;
            cmd_val <= csn;
            cmd2_reg <= REG_WAKE;
            cmd2_val <= 8'h00;
            csn <= csn + 8'h01;
            retry <= 4'h0;
          end else if (retry == MAX_RETRY - 4'h1) begin
            // RQ18 park all cards in wait for key
            cmd_reg <= REG_CFG_CTRL;
            cmd_val <= CFG_WAIT_KEY;
            cmd2_valid <= 1'b0;
            cmd_ret <= S_DONE;
          end else begin
            // RQ12 conflict: wake, relocate, wait again
            retry <= retry + 4'h1;
            cmd_reg <= REG_WAKE;
            cmd_val <= 8'h00;
            cmd2_reg <= REG_SET_RDP;
            cmd2_val <= next_rdp[8] ? RDP_MIN_IDX : next_rdp[7:0];
            rdp_idx <= next_rdp[8] ? RDP_MIN_IDX : next_rdp[7:0];
          end
        end
        default: state <= S_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Key and bit counters
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      key_cnt <= 6'h00;
      bit_idx <= 7'h00;
    end else begin
      if (state inside {S_IDLE, S_DONE}) key_cnt <= 6'h00;
      else if (state == S_KEY && bus.ack) key_cnt <= key_cnt + 6'h01;
      if (state == S_ISOWAIT) bit_idx <= 7'h00;
      else if (state == S_DECIDE) bit_idx <= bit_idx + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, identifier and results
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd1 <= 8'h00;
      rd2 <= 8'h00;
      id <= 64'h0;
      chk <= 8'h00;
      any_one <= 1'b0;
      o_card_valid <= 1'b0;
      o_card_id <= 64'h0;
      o_card_csn <= 8'h00;
    end else begin
      o_card_valid <= 1'b0;
      if (state == S_RD1 && bus.ack) rd1 <= bus.rdata;
      if (state == S_RD2 && bus.ack) rd2 <= bus.rdata;
      if (state == S_ISOWAIT) any_one <= 1'b0;
      // RQ8 one only for the full pattern
      if (state == S_DECIDE) begin
        if (pair_one) any_one <= 1'b1;
        if (bit_idx < ID_BITS) id[bit_idx[5:0]] <= pair_one;
        else chk[bit_idx[2:0]] <= pair_one;
      end
      // RQ9 checksum must match
      if (state == S_CHECK && success) begin
        o_card_valid <= 1'b1;
        o_card_id <= id;
        o_card_csn <= csn;
      end
    end
  end

  // RQ20 only card control registers are written, never device ones, RQ21 resource data is never read here
  assign o_reset_drv = (state == S_RSTDRV);
  assign o_busy = !(state inside {S_IDLE, S_DONE});
  assign o_done = (state == S_DONE);
  assign o_rd_port = {rdp_idx, RDP_LOW_BITS};

  ////////////////////////////////////////////////////////////////////////////////
  // Helper timers seen only by the checks
  logic [31:0] since_drv;
  logic [31:0] since_wake;
  logic [31:0] since_pair;
  always_ff @(posedge i_core_clk) begin
    if (i_reset || state == S_RSTDRV) since_drv <= 32'd0;
    else if (since_drv != 32'hffffffff) since_drv <= since_drv + 32'd1;
    if (i_reset || (state == S_CMD_D && bus.ack && cmd_reg == REG_WAKE)) since_wake <= 32'd0;
    else if (since_wake != 32'hffffffff) since_wake <= since_wake + 32'd1;
    if (i_reset || (state == S_RD2 && bus.ack)) since_pair <= 32'd0;
    else if (since_pair != 32'hffffffff) since_pair <= since_pair + 32'd1;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_KEY_FIRST: assert property (state == S_KEY && key_cnt == 6'h00 |-> bus.wdata == KEY_SEED) // RQ4
    else $error("key does not open with its first byte");
  AST_KEY_LAST: assert property (state == S_KEY && key_cnt == KEY_LEN - 6'h01 |->
      bus.wdata == KEY_LAST) // RQ4
    else $error("key does not end with its last byte");
  AST_READ_RANGE: assert property (bus.req && !bus.wr |->
      bus.addr >= 16'h0203 && bus.addr <= 16'h03ff && bus.addr[1:0] == RDP_LOW_BITS) // RQ3
    else $error("read data port out of range");
  AST_72_PAIRS: assert property (state == S_DECIDE && bit_idx == 7'd71 |=> state == S_CHECK) // RQ7
    else $error("isolation did not end after 72 pairs");
  AST_ONE_BIT: assert property (state == S_DECIDE && bit_idx < ID_BITS |=>
      id[$past(bit_idx[5:0])] == $past(pair_one)) // RQ8
    else $error("identifier bit decided wrongly");
  AST_CHECKSUM: assert property ($rose(o_card_valid) |-> $past(chk == lfsr && any_one)) // RQ9
    else $error("card accepted with bad checksum");
  AST_FIRST_GAP: assert property ($rose(state == S_RD1) && bit_idx == 7'h00 |->
      since_wake >= ISO_FIRST_CYCLES) // RQ16
    else $error("first pair too soon after wake");
  AST_PAIR_GAP: assert property ($rose(state == S_RD1) && bit_idx != 7'h00 |->
      since_pair >= ISO_PAIR_CYCLES) // RQ16
    else $error("pairs too close together");
  AST_RST_GAP: assert property (bus.req |-> since_drv >= RST_WAIT_CYCLES) // RQ17
    else $error("port access too soon after reset");
  AST_CONFLICT: assert property (state == S_CHECK && !success && retry != MAX_RETRY - 4'h1 |=>
      state == S_CMD_A && cmd_reg == REG_WAKE && cmd2_reg == REG_SET_RDP) // RQ12
    else $error("conflict not followed by wake and relocation");
  COV_CARD: cover property (o_card_valid);
  COV_CONFLICT: cover property (state == S_CHECK && !success);
  COV_DONE: cover property ($rose(o_done));
endmodule : pnp_isolation_host

// >>> dv/pnp_card_model.sv
// Behavioural plug and play card answering the host on the ISA bus
`timescale 1ns/1ps
module pnp_card_model #(
  parameter int unsigned RSTW = 50,
  parameter int unsigned FIRSTW = 40,
  parameter int unsigned PAIRW = 10,
  parameter logic RDY_EN = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_reset_drv,
  input wire logic [15:0] i_addr,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [7:0] i_wdata,
  input wire logic i_bad_sum,
  input wire logic [63:0] i_id,
  output logic [7:0] o_rdata,
  output logic o_iochrdy,
  output int o_viol,
  output logic [1:0] o_state,
  output logic [9:0] o_rdp,
  output logic [7:0] o_csn
);
  logic [7:0] reg_idx, key_exp;
  logic [7:0] fl = 8'h00;
  logic [5:0] key_cnt;
  logic [6:0] bit_pos;
  logic half, fresh, pior, piow, phit, rd_hit;
  logic [71:0] ser;
  logic [11:0] a12;
  int gap, since;

  initial o_state = 2'h0;

  // Identifier then its checksum, least significant bit first
  function automatic logic [71:0] build(input logic [63:0] id, input logic bad);
    logic [7:0] s;
    s = 8'h6a;
    for (int i = 0; i < 64; i++) s = {s[1] ^ s[0] ^ id[i], s[7:1]};
    return {s ^ {7'h00, bad}, id};
  endfunction : build

  task automatic enter_iso();
    o_state <= 2'h2;
    bit_pos <= 7'h00;
    half <= 1'b0;
    fresh <= 1'b1;
    gap <= 0;
    ser <= build(i_id, i_bad_sum);
  endtask : enter_iso
////////////////////////////////////////
  // twelve bit decode
  assign a12 = i_addr[11:0];
  assign rd_hit = !i_ior_n && a12 == {2'b00, o_rdp} && o_state == 2'h2
                  && reg_idx == 8'h01 && bit_pos < 7'd72;
  // pattern per one bit; an undriven bus wanders each cycle
  assign o_rdata = (rd_hit && ser[bit_pos]) ? (half ? 8'haa : 8'h55) : fl;
  assign o_iochrdy = !(RDY_EN && o_state != 2'h2 && fl[1]);

  always @(posedge i_core_clk) begin
    pior <= i_ior_n;
    piow <= i_iow_n;
    phit <= rd_hit;
    fl <= fl + 8'h3b;
    gap <= gap + 1;
    since <= since + 1;
    if (i_reset_drv) begin
      o_state <= 2'h0;
      key_cnt <= 6'h00;
      key_exp <= 8'h6a;
      o_csn <= 8'h00;
      o_rdp <= 10'h203;
      reg_idx <= 8'h00;
      bit_pos <= 7'h00;
      o_viol <= 0;
      since <= 0;
    end else begin
      if (((pior && !i_ior_n) || (piow && !i_iow_n)) && since < RSTW) o_viol <= o_viol + 1;
      if (!phit && rd_hit && !half && gap < (fresh ? FIRSTW : PAIRW)) o_viol <= o_viol + 1;
      if (phit && i_ior_n) begin
        half <= !half;
        fresh <= 1'b0;
        if (half) begin
          bit_pos <= bit_pos + 7'd1;
          gap <= 0;
        end
      end
      if (!piow && i_iow_n && a12 == 12'h279) begin
        reg_idx <= i_wdata;
        if (o_state == 2'h0) begin
          key_exp <= {key_exp[1] ^ key_exp[0], key_exp[7:1]};
          key_cnt <= key_cnt + 6'd1;
          if (i_wdata != key_exp) begin
            key_exp <= (i_wdata == 8'h6a) ? 8'hb5 : 8'h6a;
            key_cnt <= (i_wdata == 8'h6a) ? 6'd1 : 6'd0;
          end else if (key_cnt == 6'd31) begin
            enter_iso();
          end
        end
      end
      if (!piow && i_iow_n && a12 == 12'ha79 && o_state != 2'h0) begin
        case (reg_idx)
          8'h00: o_rdp <= {i_wdata, 2'b11};
          8'h02: if (i_wdata[1]) begin
            o_state <= 2'h0;
            key_cnt <= 6'h00;
            key_exp <= 8'h6a;
          end
          8'h03: if (i_wdata == o_csn) begin
            enter_iso();
          end else begin
            o_state <= 2'h1;
          end
          8'h06: if (o_state == 2'h2) begin
            o_csn <= i_wdata;
            o_state <= 2'h3;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : pnp_card_model

// >>> dv/test_isa_pnp_config_isolation.sv
// Self-checking bench: enumeration host against one behavioural card
`timescale 1ns/1ps
module test_isa_pnp_config_isolation;
  logic i_core_clk, i_reset, i_start, i_iochrdy, bad;
  logic [7:0] i_data, o_data, o_card_csn, m_csn;
  logic [15:0] o_isa_addr;
  logic o_ior_n, o_iow_n, o_data_oe, o_reset_drv, o_busy, o_done, o_card_valid;
  logic [63:0] o_card_id, id, want;
  logic [9:0] o_rd_port, m_rdp;
  logic [1:0] m_state;
  int viol, error_cnt, checked, seen;
  logic [63:0] exp_q[$];

  // Short waits keep the run small; the card uses the same figures
  pnp_isolation_host #(
    .RST_WAIT_CYCLES(50), .ISO_FIRST_CYCLES(40), .ISO_PAIR_CYCLES(10), .MAX_RETRY(4'h2)
  ) uut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_start(i_start), .i_data(i_data),
    .i_iochrdy(i_iochrdy), .o_isa_addr(o_isa_addr), .o_ior_n(o_ior_n), .o_iow_n(o_iow_n),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_reset_drv(o_reset_drv), .o_busy(o_busy),
    .o_done(o_done), .o_card_valid(o_card_valid), .o_card_id(o_card_id),
    .o_card_csn(o_card_csn), .o_rd_port(o_rd_port)
  );

  // Card defaults already match the short waits given to the host above
  pnp_card_model card (
    .i_core_clk(i_core_clk), .i_reset_drv(o_reset_drv), .i_addr(o_isa_addr),
    .i_ior_n(o_ior_n), .i_iow_n(o_iow_n), .i_wdata(o_data), .i_bad_sum(bad), .i_id(id),
    .o_rdata(i_data), .o_iochrdy(i_iochrdy), .o_viol(viol), .o_state(m_state),
    .o_rdp(m_rdp), .o_csn(m_csn)
  );
////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Every found card is compared with the queue of cards put on the bus
  always @(negedge i_core_clk) begin
    if (o_iow_n === 1'b0) check(o_data_oe === 1'b1, "write data not driven");
    if (o_card_valid === 1'b1) begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
      seen++;
      check(o_card_id === want, "card identifier");
      check(o_card_csn === 8'(seen), "card number");
    end
  end

  task automatic run(input logic corrupt, input int cards);
    int n;
    @(negedge i_core_clk);
    bad = corrupt;
    id = {$urandom, $urandom} | 64'h1;
    if (cards > 0) exp_q.push_back(id);
    seen = 0;
    i_reset = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_reset = 1'b0;
    for (n = 0; n < 400 && o_busy !== 1'b0; n++) @(negedge i_core_clk);
    check(n < 400, "reset quiet time");
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
    for (n = 0; n < 70000 && o_done !== 1'b1; n++) @(negedge i_core_clk);
    if (n >= 70000) begin
      check(1'b0, "enumeration timeout");
    end else begin
      check(seen === cards, "card count");
      check(exp_q.size() === 0, "card missing");
      check(m_state === 2'h0, "card not back to key wait");
      check(m_rdp === o_rd_port, "read port mismatch");
      check(viol === 0, "access spacing");
    end
  endtask : run

  initial begin
    i_reset = 1'b1;
    i_start = 1'b0;
    bad = 1'b0;
    id = 64'h0;
    error_cnt = 0;
    checked = 0;
    seen = 0;
    void'($urandom(32'h8aae6814));
    run(1'b0, 1);
    check(m_csn === 8'h01, "card kept no number");
    run(1'b1, 0);
    check(m_rdp !== 10'h203, "read port not moved");
    report_and_stop();
  end
endmodule : test_isa_pnp_config_isolation
